// ---- rtl/ube_pkg.sv ----
// Constants, types and helpers for the upstream burst encoder.
// Assumes one 125 MHz clock and a simple register port master.
package ube_pkg;
    // Register word addresses
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_FEC    = 8'h01;
    localparam logic [7:0]  ADDR_SEED   = 8'h02;
    localparam logic [7:0]  ADDR_PRELEN = 8'h03;
    localparam logic [7:0]  ADDR_STAT   = 8'h04;
    localparam logic [2:0]  ADDR_PRE_HI = 3'h1;      // 0x20..0x3F preamble words
    // Field positions in control and status words
    localparam int          CTRL_GO     = 0;
    localparam int          CTRL_QAM    = 1;
    localparam int          CTRL_DIFF   = 2;
    localparam int          CTRL_SCR    = 3;
    localparam int          CTRL_SHORT  = 4;
    localparam int          CTRL_RATE   = 8;
    localparam int          STAT_BUSY   = 0;
    localparam int          STAT_UNDER  = 1;
    // Limits and reset values
    localparam logic [3:0]  FEC_T_MAX   = 4'hA;
    localparam logic [7:0]  INFO_K_MIN  = 8'h10;
    localparam logic [7:0]  INFO_K_RST  = 8'h10;
    localparam logic [2:0]  RATE_MAX    = 3'h4;
    localparam logic [14:0] SEED_RST    = 15'h0000;
    localparam logic [10:0] PRELEN_MAX  = 11'h400;
    // Symbol pacing: rate in ksym/s against clock in kHz
    localparam logic [16:0] CLK_KHZ     = 17'h1_E848;  // 125000 kHz
    localparam logic [16:0] RATE_MIN    = 17'h0_00A0;  // 160 ksym/s
    localparam logic [3:0]  BPS_QPSK    = 4'h2;
    localparam logic [3:0]  BPS_QAM16   = 4'h4;
    localparam logic [3:0]  BYTE_BITS   = 4'h8;
    // Galois field constants
    localparam logic [7:0]  GF_POLY     = 8'h1D;
    localparam logic [7:0]  GF_ALPHA    = 8'h02;

    typedef logic [20:0][7:0] ube_gen_t;   // Generator coefficients, g[0] constant term
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PRE  = 3'b001,
        ST_DATA = 3'b010,
        ST_PAR  = 3'b011,
        ST_END  = 3'b100
    } ube_state_t;

    function automatic logic [7:0] gfMul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) p = p ^ x;
            x = x[7] ? ({x[6:0], 1'b0} ^ GF_POLY) : {x[6:0], 1'b0};
        end
        return p;
    endfunction

    // product of (x + alpha^i), i below 2T
    function automatic ube_gen_t genPoly(input int t);
        ube_gen_t   g;
        logic [7:0] root;
        g = '0;
        g[0] = 8'h01;
        root = 8'h01;
        for (int i = 0; i < 2 * t; i++) begin
            for (int j = 20; j > 0; j--) g[j] = g[j-1] ^ gfMul(g[j], root);
            g[0] = gfMul(g[0], root);
            root = gfMul(root, GF_ALPHA);
        end
        return g;
    endfunction

    // one quarter turn of the quadrant pair
    function automatic logic [1:0] rotStep(input logic [1:0] q);
        case (q)
            2'b11:   return 2'b01;
            2'b01:   return 2'b00;
            2'b00:   return 2'b10;
            default: return 2'b11;
        endcase
    endfunction

    // sign from MSB, magnitude from LSB in 16QAM
    function automatic logic signed [2:0] level(input logic msb, input logic lsb,
                                                input logic qam);
        logic signed [2:0] m;
        m = (qam && !lsb) ? 3'sd3 : 3'sd1;
        return msb ? -m : m;
    endfunction

    function automatic logic [7:0] revByte(input logic [7:0] b);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) r[i] = b[7-i];
        return r;
    endfunction
endpackage

// ---- rtl/ube_encoder.sv ----
// Upstream burst encoder: FEC, scrambler, preamble and symbol mapper.
// Assumes the MAC keeps up with the handshake and bursts start idle.
module ube_encoder
    import ube_pkg::*;
(
    // Clock, enable, reset
    input  wire logic              clock,
    input  wire logic              clockEn,
    input  wire logic              nrst,
    // Register port
    input  wire logic [7:0]        regAddr,
    input  wire logic [31:0]       regWrData,
    input  wire logic              regWrStrobe,
    input  wire logic              regRdStrobe,
    output logic      [31:0]       regRdData,
    // Byte stream from MAC
    input  wire logic [7:0]        inByte,
    input  wire logic              inValid,
    input  wire logic              inLast,
    output logic                   inReady,
    // Symbols to the pulse shaper
    output logic signed [2:0]      symI,
    output logic signed [2:0]      symQ,
    output logic                   symValid,
    output logic                   burstBusy
);
    // Configuration registers
    logic              qam_r;            // 16QAM when set
    logic              diff_r;           // Differential quadrants
    logic              scrOn_r;          // Scrambler enable
    logic              short_r;          // Shortened last codeword
    logic [2:0]        rate_r;           // Rate select
    logic [3:0]        fecT_r;           // Correctable bytes, 0 bypass
    logic [7:0]        infoK_r;          // Info bytes per codeword
    logic [14:0]       seed_r;           // Scrambler seed
    logic [10:0]       preLen_r;         // Preamble bits
    logic [31:0]       preMem_r [32];    // Preamble pattern, bit 31 first
    logic              under_r;          // Sticky underrun
    logic [31:0]       rdData_r;
    // Datapath state
    ube_state_t        state_r;
    logic [16:0]       acc_r;            // Symbol rate accumulator
    logic [7:0]        shBuf_r;          // Current byte, MSB next
    logic [3:0]        bitCnt_r;         // Bits left in shBuf_r
    logic [7:0]        infoCnt_r;        // Info bytes in codeword
    logic              lastSeen_r;       // Burst's last byte taken
    logic              pad_r;            // Zero filling last codeword
    logic [7:0]        par_r [20];       // Parity register
    logic [4:0]        parLeft_r;        // Parity bytes still to send
    logic [10:0]       preIdx_r;         // Next preamble bit
    logic [14:0]       scr_r;            // Scrambler shift register
    logic [1:0]        prevQuad_r;       // Last sent quadrant
    logic              inReady_r;
    logic signed [2:0] symI_r;
    logic signed [2:0] symQ_r;
    logic              symValid_r;

    // Register decode
    wire logic  busy    = (state_r != ST_IDLE);
    wire logic  wrCtrl  = regWrStrobe && (regAddr == ADDR_CTRL);
    wire logic  wrFec   = regWrStrobe && (regAddr == ADDR_FEC);
    wire logic  wrSeed  = regWrStrobe && (regAddr == ADDR_SEED);
    wire logic  wrLen   = regWrStrobe && (regAddr == ADDR_PRELEN);
    wire logic  wrStat  = regWrStrobe && (regAddr == ADDR_STAT);
    wire logic  wrPre   = regWrStrobe && (regAddr[7:5] == ADDR_PRE_HI);
    wire logic  go      = wrCtrl && regWrData[CTRL_GO] && !busy;
    // Clamped write values
    wire logic [3:0]  wT    = (regWrData[3:0] > FEC_T_MAX) ? FEC_T_MAX : regWrData[3:0];
    wire logic [7:0]  wK    = (regWrData[15:8] < INFO_K_MIN) ? INFO_K_MIN : regWrData[15:8];
    wire logic [2:0]  wRate = (regWrData[10:8] > RATE_MAX) ? RATE_MAX : regWrData[10:8];
    wire logic [10:0] wLen  = (regWrData[10:0] > PRELEN_MAX) ? PRELEN_MAX : regWrData[10:0];

    // Symbol pacing
    wire logic [3:0]  bps     = qam_r ? BPS_QAM16 : BPS_QPSK;
    wire logic [16:0] rateK   = RATE_MIN << rate_r;
    wire logic [17:0] accSum  = {1'b0, acc_r} + {1'b0, rateK};
    wire logic [17:0] accWrap = accSum - {1'b0, CLK_KHZ};
    wire logic        tick    = busy && (accSum >= {1'b0, CLK_KHZ});
    wire logic [16:0] accNext = tick ? accWrap[16:0] : accSum[16:0];

    // Bit source selection
    wire logic        inPre    = (state_r == ST_PRE);
    wire logic        haveBits = inPre || (bitCnt_r != 4'h0);
    wire logic        take     = tick && haveBits;
    wire logic [31:0] preShl   = preMem_r[preIdx_r[9:5]] << preIdx_r[4:0];
    wire logic [3:0]  rawBits  = inPre ? preShl[31:28] : shBuf_r[7:4];
    wire logic [11:0] preSum   = {1'b0, preIdx_r} + {8'h00, bps};
    wire logic        preDone  = preSum >= {1'b0, preLen_r};

    logic [14:0] scrSt [5];
    logic [3:0]  scrBit;
    assign scrSt[0] = scr_r;
    for (genvar k = 0; k < 4; k++) begin : g_scr
        assign scrBit[3-k]  = scrSt[k][14] ^ scrSt[k][13];
        assign scrSt[k+1]   = {scrSt[k][13:0], scrBit[3-k]};
    end
    wire logic        useScr  = scrOn_r && !inPre;
    wire logic [3:0]  symBits = rawBits ^ (useScr ? scrBit : 4'h0);
    wire logic [14:0] scrNext = qam_r ? scrSt[4] : scrSt[2];

    // first bit inphase_msb, then quad_msb, inphase_lsb, quad_lsb
    wire logic inphaseMsb = symBits[3];
    wire logic quadMsb    = symBits[2];
    wire logic inphaseLsb = qam_r && symBits[1];
    wire logic quadLsb    = qam_r && symBits[0];
    wire logic [1:0] steps = {inphaseMsb, inphaseMsb ^ quadMsb};
    wire logic [1:0] rot1  = rotStep(prevQuad_r);
    wire logic [1:0] rot2  = rotStep(rot1);
    wire logic [1:0] rot3  = rotStep(rot2);
    wire logic [1:0] rotQ  = (steps == 2'd0) ? prevQuad_r :
                             (steps == 2'd1) ? rot1 : (steps == 2'd2) ? rot2 : rot3;
    // applies to every symbol of the burst
    wire logic [1:0] quadCur = diff_r ? rotQ : {inphaseMsb, quadMsb};

    // Byte fill from MAC or zero padding
    wire logic       need     = (state_r == ST_DATA) && (bitCnt_r == 4'h0);
    wire logic       accept   = inValid && inReady_r;
    wire logic       loadData = need && (accept || pad_r);
    // first serial bit becomes RS symbol MSB
    wire logic [7:0] fillByte = pad_r ? 8'h00 : revByte(inByte);
    wire logic       fillLast = !pad_r && inLast;
    wire logic [8:0] cntInc   = {1'b0, infoCnt_r} + 9'h001;
    wire logic       cntDone  = (cntInc == {1'b0, infoK_r});
    wire logic       fecOn    = (fecT_r != 4'h0);
    wire logic [4:0] twoT     = {fecT_r, 1'b0};
    wire logic [4:0] parTopIx = twoT - 5'h01;
    wire logic [7:0] parTop   = par_r[parTopIx];
    wire logic       parEmit  = (state_r == ST_PAR) && (bitCnt_r == 4'h0) && (parLeft_r != 5'h00);

    // generator tables for T of 0 to 10
    ube_gen_t   genTab [11];
    for (genvar t = 0; t <= 10; t++) begin : g_gen
        assign genTab[t] = genPoly(t);
    end
    wire ube_gen_t   genSel = genTab[fecT_r];
    wire logic [7:0] fb     = fillByte ^ parTop;
    logic [7:0] parUpd [20];
    logic [7:0] parShf [20];
    for (genvar j = 0; j < 20; j++) begin : g_par
        if (j == 0) begin : g_lo
            assign parUpd[j] = gfMul(fb, genSel[j]);
            assign parShf[j] = 8'h00;
        end else begin : g_hi
            assign parUpd[j] = par_r[j-1] ^ gfMul(fb, genSel[j]);
            assign parShf[j] = par_r[j-1];
        end
    end

    // Configuration writes
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            qam_r    <= 1'b0;
            diff_r   <= 1'b0;
            scrOn_r  <= 1'b0;
            short_r  <= 1'b0;
            rate_r   <= 3'h0;
            fecT_r   <= 4'h0;
            infoK_r  <= INFO_K_RST;
            seed_r   <= SEED_RST;
            preLen_r <= 11'h000;
        end else if (clockEn && !busy) begin
            if (wrCtrl) begin
                qam_r   <= regWrData[CTRL_QAM];
                diff_r  <= regWrData[CTRL_DIFF];
                scrOn_r <= regWrData[CTRL_SCR];
                short_r <= regWrData[CTRL_SHORT];
                rate_r  <= wRate;
            end
            // info bytes kept at sixteen or more
            if (wrFec) begin
                fecT_r  <= wT;
                infoK_r <= wK;
            end
            if (wrSeed) seed_r <= regWrData[14:0];
            if (wrLen) preLen_r <= wLen;
        end
    end

    // Preamble pattern store
    for (genvar w = 0; w < 32; w++) begin : g_pre
        always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) preMem_r[w] <= 32'h0000_0000;
            else if (clockEn && !busy && wrPre && regAddr[4:0] == w) preMem_r[w] <= regWrData;
        end
    end

    // Read data, valid only the cycle after the strobe
    wire logic [31:0] rdMux =
        (regAddr == ADDR_CTRL)   ? {21'h0, rate_r, 3'h0, short_r, scrOn_r, diff_r, qam_r, 1'b0} :
        (regAddr == ADDR_FEC)    ? {16'h0, infoK_r, 4'h0, fecT_r} :
        (regAddr == ADDR_SEED)   ? {17'h0, seed_r} :
        (regAddr == ADDR_PRELEN) ? {21'h0, preLen_r} :
        (regAddr == ADDR_STAT)   ? {30'h0, under_r, busy} :
        (regAddr[7:5] == ADDR_PRE_HI) ? preMem_r[regAddr[4:0]] : 32'h0000_0000;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) rdData_r <= 32'h0000_0000;
        else if (clockEn) rdData_r <= regRdStrobe ? rdMux : 32'h0000_0000;
    end

    // Underrun flag, a new event beats the clear
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) under_r <= 1'b0;
        else if (clockEn) begin
            if (tick && !haveBits) under_r <= 1'b1;
            else if (wrStat && regWrData[STAT_UNDER]) under_r <= 1'b0;
        end
    end

    // Pacing, scrambler and quadrant memory
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            acc_r      <= 17'h0_0000;
            scr_r      <= 15'h0000;
            prevQuad_r <= 2'b00;
        end else if (clockEn) begin
            if (go) begin
                acc_r      <= 17'h0_0000;
                scr_r      <= seed_r;
                prevQuad_r <= 2'b00;
            end else begin
                if (busy) acc_r <= accNext;
                if (take && useScr) scr_r <= scrNext;
                if (take) prevQuad_r <= quadCur;
            end
        end
    end

    // Symbol output register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            symI_r     <= 3'sd0;
            symQ_r     <= 3'sd0;
            symValid_r <= 1'b0;
        end else if (clockEn) begin
            symValid_r <= take;
            if (take) begin
                symI_r <= level(quadCur[1], inphaseLsb, qam_r);
                symQ_r <= level(quadCur[0], quadLsb, qam_r);
            end
        end
    end

    // ready only when a byte is wanted
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) inReady_r <= 1'b0;
        else if (clockEn) inReady_r <= need && !pad_r && !lastSeen_r && !accept;
    end

    // Reed-Solomon parity register
    for (genvar j = 0; j < 20; j++) begin : g_parq
        always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) par_r[j] <= 8'h00;
            else if (clockEn) begin
                if (go) par_r[j] <= 8'h00;
                else if (loadData && fecOn) par_r[j] <= parUpd[j];
                else if (parEmit) par_r[j] <= parShf[j];
            end
        end
    end

    // Burst sequencer and bit buffer
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_r    <= ST_IDLE;
            shBuf_r    <= 8'h00;
            bitCnt_r   <= 4'h0;
            infoCnt_r  <= 8'h00;
            lastSeen_r <= 1'b0;
            pad_r      <= 1'b0;
            parLeft_r  <= 5'h00;
            preIdx_r   <= 11'h000;
        end else if (clockEn) begin
            if (take && !inPre) begin
                shBuf_r  <= shBuf_r << bps;
                bitCnt_r <= bitCnt_r - bps;
            end
            case (state_r)
                ST_IDLE: begin
                    if (go) begin
                        infoCnt_r  <= 8'h00;
                        lastSeen_r <= 1'b0;
                        pad_r      <= 1'b0;
                        preIdx_r   <= 11'h000;
                        state_r    <= (preLen_r == 11'h000) ? ST_DATA : ST_PRE;
                    end
                end
                ST_PRE: begin
                    if (take) begin
                        preIdx_r <= preSum[10:0];
                        if (preDone) state_r <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (loadData) begin
                        shBuf_r   <= fillByte;
                        bitCnt_r  <= BYTE_BITS;
                        infoCnt_r <= cntInc[7:0];
                        if (fillLast) lastSeen_r <= 1'b1;
                        if (!fecOn) begin
                            if (fillLast) state_r <= ST_END;
                        end else if (cntDone || (fillLast && short_r)) begin
                            state_r   <= ST_PAR;
                            parLeft_r <= twoT;
                            pad_r     <= 1'b0;
                        end else if (fillLast) begin
                            pad_r <= 1'b1;
                        end
                    end
                end
                ST_PAR: begin
                    if (bitCnt_r == 4'h0) begin
                        if (parLeft_r != 5'h00) begin
                            shBuf_r   <= parTop;
                            bitCnt_r  <= BYTE_BITS;
                            parLeft_r <= parLeft_r - 5'h01;
                        end else if (lastSeen_r) begin
                            state_r <= ST_IDLE;
                        end else begin
                            infoCnt_r <= 8'h00;
                            state_r   <= ST_DATA;
                        end
                    end
                end
                ST_END: begin
                    if (bitCnt_r == 4'h0) state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Outputs straight from flip-flops, burstBusy decoded from state_r
    assign regRdData = rdData_r;
    assign inReady   = inReady_r;
    assign symI      = symI_r;
    assign symQ      = symQ_r;
    assign symValid  = symValid_r;
    assign burstBusy = (state_r != ST_IDLE);
endmodule

// ---- verification/ube_encoder_asserts.sv ----
// Port checker for the upstream burst encoder.
// Assumes one clock domain; bound onto the encoder from the bench.
module ube_encoder_asserts
    import ube_pkg::*;
(
    // Clock, reset
    input wire logic              clock,
    input wire logic              nrst,
    // Register port
    input wire logic [7:0]        regAddr,
    input wire logic [31:0]       regWrData,
    input wire logic              regWrStrobe,
    input wire logic              regRdStrobe,
    input wire logic [31:0]       regRdData,
    // Byte and symbol streams
    input wire logic              inValid,
    input wire logic              inReady,
    input wire logic signed [2:0] symI,
    input wire logic signed [2:0] symQ,
    input wire logic              symValid,
    input wire logic              burstBusy
);
    default clocking dc @(posedge clock); endclocking
    default disable iff (!nrst);
    // Go written while idle
    sequence s_go;
        regWrStrobe && regAddr == ADDR_CTRL && regWrData[CTRL_GO] && !burstBusy;
    endsequence
    // Byte taken by the encoder
    sequence s_take;
        inValid && inReady;
    endsequence
    property p_go; s_go |=> burstBusy; endproperty
    a_go: assert property (p_go) else $error("go did not start burst");
    property p_take; s_take |=> !inReady [*2]; endproperty
    a_take: assert property (p_take) else $error("ready not dropped");
    property p_idle; !burstBusy |-> !inReady; endproperty
    a_idle: assert property (p_idle) else $error("ready while idle");
    property p_gap; symValid |=> !symValid [*8]; endproperty
    a_gap: assert property (p_gap) else $error("symbols too close");
    property p_lvl; symValid |-> symI inside {-3, -1, 1, 3} && symQ inside {-3, -1, 1, 3};
    endproperty
    a_lvl: assert property (p_lvl) else $error("level off grid");
    property p_hold; !symValid |-> $stable(symI) && $stable(symQ); endproperty
    a_hold: assert property (p_hold) else $error("symbol moved between pulses");
    property p_busy; symValid |-> burstBusy || $past(burstBusy); endproperty
    a_busy: assert property (p_busy) else $error("symbol outside burst");
    property p_rd; !$past(regRdStrobe) |-> regRdData == 32'h0000_0000; endproperty
    a_rd: assert property (p_rd) else $error("read data outside slot");
endmodule

// ---- verification/ube_mac_model.sv ----
// Byte source in place of the MAC layer.
// Assumes the bench queues bytes and an idle gap between bytes.
module ube_mac_model (
    // Clock, reset
    input wire logic  clock,
    input wire logic  nrst,
    // Byte stream
    input wire logic  inReady,
    output logic [7:0] inByte,
    output logic       inValid,
    output logic       inLast
);
    logic [7:0] bytes[$];  // Bytes still to send
    int         gap = 0;   // Idle cycles after each taken byte, less one
    int         waitN;     // Idle cycles left
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            inValid <= 1'b0;
            inLast  <= 1'b0;
            inByte  <= 8'h00;
            waitN   <= 0;
        end else if (inValid && inReady) begin
            // Taken: drop valid, spoil stale byte
            inValid <= 1'b0;
            inLast  <= 1'b0;
            inByte  <= ~inByte;
            waitN   <= gap;
        end else if (!inValid && bytes.size() > 0) begin
            if (waitN > 0) begin
                waitN <= waitN - 1;
            end else begin
                inValid <= 1'b1;
                inByte  <= bytes[0];
                inLast  <= bytes.size() == 1;
                void'(bytes.pop_front());
            end
        end
    end
endmodule

// ---- verification/ube_encoder_bench.sv ----
// Self-checking bench for the upstream burst encoder.
// Assumes the package, encoder, MAC model and checker are compiled.
module ube_encoder_bench
    import ube_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, nrst = 1'b0, regWrStrobe = 1'b0, regRdStrobe = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0000_0000, regRdData;
    logic [7:0]  inByte;
    logic        inValid, inLast, inReady, symValid, burstBusy;
    logic signed [2:0] symI, symQ;
    logic [5:0]  seen[$];       // Symbols captured
    int          seenT[$];      // Capture cycle of each
    logic [1:0]  rot[4] = '{2'b10, 2'b00, 2'b11, 2'b01}; // Quarter turn
    int          errCount = 0, testsRun = 0;
    always #4 clock = ~clock;
    ube_encoder DUT (.clock(clock), .clockEn(1'b1), .nrst(nrst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
        .regRdData(regRdData), .inByte(inByte), .inValid(inValid), .inLast(inLast),
        .inReady(inReady), .symI(symI), .symQ(symQ), .symValid(symValid),
        .burstBusy(burstBusy));
    ube_mac_model mac (.clock(clock), .nrst(nrst), .inReady(inReady), .inByte(inByte),
        .inValid(inValid), .inLast(inLast));
    // Symbol capture
    always @(posedge clock) begin
        if (symValid === 1'b1) begin
            seen.push_back({symI, symQ});
            seenT.push_back(int'($time / 8));
        end
    end
    task automatic check(string what, logic [31:0] got, logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic regWr(logic [7:0] a, logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWrStrobe <= 1'b1;
        @(posedge clock);
        regWrStrobe <= 1'b0;
    endtask
    task automatic regRd(logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regRdStrobe <= 1'b1;
        @(posedge clock);
        regRdStrobe <= 1'b0;
        // Data stand in the cycle after the strobe; look once settled
        #1;
        d = regRdData;
    endtask
    function automatic logic [2:0] lv(logic m, logic l, logic qam);
        logic [2:0] a;
        a = (qam && !l) ? 3'h3 : 3'h1;
        return m ? -a : a;
    endfunction
    // One burst, then compare symbols against the bit model
    task automatic burst(logic [31:0] ctl, logic [31:0] pre, int preLen,
                         logic [14:0] seed, logic [7:0] d[$], int gap, int nCmp, int total);
        logic bits[$];
        logic [5:0] exp[$];
        logic [14:0] s;
        logic [1:0] qd, pq;
        logic [31:0] got;
        int bps, n, q;
        seen.delete();
        seenT.delete();
        regWr(ADDR_SEED, {17'h0_0000, seed});
        regWr(ADDR_PRELEN, 32'(preLen));
        regWr(8'h20, pre);
        mac.bytes = d;
        mac.gap = gap;
        regWr(ADDR_CTRL, ctl | 32'h0000_0001);
        @(posedge clock);
        check("busy", {31'h0, burstBusy}, 32'h1);
        regWr(ADDR_SEED, 32'h0000_7FFF);
        n = 0;
        while (burstBusy === 1'b1 && n < 90000) begin
            @(posedge clock);
            n++;
        end
        check("done", {31'h0, burstBusy}, 32'h0);
        repeat (3) @(posedge clock);
        regRd(ADDR_STAT, got);
        check("underrun", got, 32'h0);
        regRd(ADDR_SEED, got);
        check("seed", got, {17'h0_0000, seed});
        for (int i = 0; i < preLen; i++) bits.push_back(pre[31-i]);
        s = seed;
        foreach (d[j]) begin
            for (int b = 0; b < 8; b++) begin
                bits.push_back(d[j][b] ^ (ctl[CTRL_SCR] & (s[14] ^ s[13])));
                if (ctl[CTRL_SCR]) s = {s[13:0], s[14] ^ s[13]};
            end
        end
        bps = ctl[CTRL_QAM] ? 4 : 2;
        pq = 2'b00;
        for (int i = 0; i + bps <= bits.size(); i += bps) begin
            qd = {bits[i], bits[i+1]};
            if (ctl[CTRL_DIFF]) begin
                n = (qd == 2'b01) ? 1 : (qd == 2'b11) ? 2 : (qd == 2'b10) ? 3 : 0;
                qd = pq;
                repeat (n) qd = rot[qd];
                pq = qd;
            end
            exp.push_back({lv(qd[1], bps == 4 ? bits[i+2] : 1'b1, ctl[CTRL_QAM]),
                           lv(qd[0], bps == 4 ? bits[i+3] : 1'b1, ctl[CTRL_QAM])});
        end
        check("count", seen.size(), total);
        for (int i = 0; i < nCmp; i++) check("symbol", seen[i], exp[i]);
        q = 125000 / (160 << ctl[10:8]);
        n = seenT[1] - seenT[0];
        check("rate", n == q || n == q + 1, 1);
    endtask
    task automatic t_regs();
        logic [31:0] v;
        regRd(ADDR_FEC, v);
        check("fec reset", v, 32'h0000_1000);
        regWr(ADDR_FEC, 32'h0000_050F);
        regRd(ADDR_FEC, v);
        check("fec clamp", v, 32'h0000_100A);
        regRd(8'h10, v);
        check("unmapped", v, 32'h0000_0000);
        // Back to bypass so the mode bursts run uncoded
        regWr(ADDR_FEC, 32'h0000_1000);
        $display("register test done");
    endtask
    task automatic t_modes();
        burst(32'h0000_0400, 32'hA000_0000, 4, 15'h0000, '{8'h01, 8'hC3}, 0, 10, 10);
        burst(32'h0000_0000, 32'h4000_0000, 2, 15'h0000, '{8'h5A}, 5, 5, 5);
        burst(32'h0000_040E, 32'h9C00_0000, 8, 15'h1234, '{8'h3C, 8'hF0, 8'h81}, 0, 8, 8);
        $display("mode test done");
    endtask
    task automatic t_fec();
        logic [7:0] d[$];
        for (int i = 0; i < 17; i++) d.push_back(8'(i * 17));
        regWr(ADDR_FEC, 32'h0000_1001);
        burst(32'h0000_0400, 32'h0000_0000, 0, 15'h0000, d[0:15], 0, 64, 72);
        burst(32'h0000_0410, 32'h0000_0000, 0, 15'h0000, d, 0, 64, 84);
        regWr(ADDR_FEC, 32'h0000_1000);
        $display("fec test done");
    endtask
    task automatic endSim();
        $display("checks %0d mismatches %0d", testsRun, errCount);
        if (errCount == 0 && testsRun > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #800_000;
        errCount++;
        endSim();
    end
    initial begin
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        t_regs();
        t_modes();
        t_fec();
        endSim();
    end
endmodule
bind ube_encoder ube_encoder_asserts chk (.clock(clock), .nrst(nrst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
    .regRdData(regRdData), .inValid(inValid), .inReady(inReady), .symI(symI),
    .symQ(symQ), .symValid(symValid), .burstBusy(burstBusy));
